// file: core/bisc_pkg.sv
// Functional notes
// - stop frame lasts 2 bus clocks when bit is 0, 3 clocks when 1.
// - slots per serial interrupt cycle equal 17 plus four-bit field; default 21.
// - start pulse 4, 6 or 8 (default) bus clocks; code 11 reserved.
// - each of DMA channels 0-3,5-7 sits on ISA side at 0, PCI side at 1.
// - in burst mode, select 1 releases clock-stop after 1-2 ms, else power unit timing.
// - sync bit 1 registers steered interrupt outputs; 0 bypasses the register.
// - control bit 1 drives both USB power enables onto general pins 9 and 8.
// - a bit enables repeat of serial interrupt continuous mode.
// - power unit select answers address line 28,29,30,31 for codes 00..11.
// - enabled USB select answers address line 31,30,29,28 for codes 00..11.
// - eight-bit distributed DMA base, software writable, reset to zero.
// - bit 0 drives ISA ready during DMA cycles; bit 1 leaves it undriven.
// - lock bit makes subsystem vendor and subsystem identifiers read-only.
// - four-bit routing code selects one legacy line per common table.
// - transform bit turns each level request into an edge before steering.
// - IDE secondary interrupt steered by own code only in native mode.
// - system control interrupt code 0000 selects IRQ13 instead of none.
// - separate bit 0 permits system control interrupt on IRQ13, 1 forbids.
// - battery bus event interrupt steered by own code, 0000 disables.
// - lock bits make battery bus and ACPI base registers read-only, read zero.
// - with power unit disabled, offsets 7Ch-FFh map onto its configuration ports.
// - top bit of serial interrupt control enables serial interrupt operation.
package bisc_pkg;

   localparam logic [7:0] OFF_SERIAL_IRQ_CONTROL = 8'h70;
   localparam logic [7:0] OFF_DDMA_CHANNEL_SIDE  = 8'h71;
   localparam logic [7:0] OFF_SELECT_LINE_SYNC   = 8'h72;
   localparam logic [7:0] OFF_DDMA_BASE_ADDRESS  = 8'h73;
   localparam logic [7:0] OFF_USB_IRQ_ROUTE      = 8'h74;
   localparam logic [7:0] OFF_IDE_SEC_IRQ_ROUTE  = 8'h75;
   localparam logic [7:0] OFF_SCI_IRQ_ROUTE      = 8'h76;
   localparam logic [7:0] OFF_BATTERY_IRQ_ROUTE  = 8'h77;
   localparam logic [7:0] OFF_PMU_MAP_FIRST      = 8'h7c;

   localparam logic [7:0] RST_SERIAL_IRQ_CONTROL = 8'h12;
   localparam logic [7:0] RST_OTHER              = 8'h00;

   // writable bits per register, reserved bits stay zero
   localparam logic [7:0] WMASK_70 = 8'hff;
   localparam logic [7:0] WMASK_71 = 8'hff;
   localparam logic [7:0] WMASK_72 = 8'hef;
   localparam logic [7:0] WMASK_73 = 8'hff;
   localparam logic [7:0] WMASK_74 = 8'hdf;
   localparam logic [7:0] WMASK_75 = 8'h1f;
   localparam logic [7:0] WMASK_76 = 8'h9f;
   localparam logic [7:0] WMASK_77 = 8'hdf;

   // 0x70 fields
   localparam int SIRQ_ENABLE_BIT   = 7;
   localparam int SIRQ_STOP_BIT     = 6;
   localparam int SIRQ_FRAMES_LSB   = 2;
   localparam int SIRQ_START_LSB    = 0;
   // 0x71 fields
   localparam int STOP_SELECT_BIT   = 4;
   // 0x72 fields
   localparam int SYNC_BIT          = 7;
   localparam int USB_PWREN_GPIO_BIT = 6;
   localparam int REPEAT_CONT_BIT   = 5;
   localparam int PMU_IDSEL_LSB     = 2;
   localparam int USB_IDSEL_LSB     = 0;
   // route register fields
   localparam int ROUTE_CODE_LSB    = 0;
   localparam int EDGE_BIT          = 4;
   localparam int READY_NODRIVE_BIT = 7;
   localparam int SUBSYS_LOCK_BIT   = 6;
   localparam int SCI_IRQ13_OFF_BIT = 7;
   localparam int BATTERY_LOCK_BIT  = 7;
   localparam int ACPI_LOCK_BIT     = 6;

   localparam logic [4:0] SLOT_BASE     = 5'h11;
   localparam logic [3:0] STOP_QUIET    = 4'h2;
   localparam logic [3:0] STOP_CONT     = 4'h3;
   localparam logic [3:0] START_W0      = 4'h4;
   localparam logic [3:0] START_W1      = 4'h6;
   localparam logic [3:0] START_W2      = 4'h8;
   localparam logic [3:0] IRQ13_LINE    = 4'hd;

   localparam int CLK_PERIOD_NS     = 50;
   localparam int STOP_HOLD_TIME_US = 1000;
   localparam int STOP_HOLD_CYCLES  = (STOP_HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int NUM_SRC = 4;

   typedef struct packed {
      logic       enable;
      logic       repeat_continuous;
      logic [3:0] stop_clocks;
      logic [5:0] slot_count;
      logic [3:0] start_clocks;
      logic       start_reserved;
   } bisc_sirq_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } bisc_cfg_req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic       rvalid;
   } bisc_cfg_rsp_t;

endpackage : bisc_pkg

// file: core/bisc_bridge_irq_steering_config.sv
`timescale 1ns/1ps
`default_nettype none
module bisc_bridge_irq_steering_config
   import bisc_pkg::*;
#(
   parameter int STOP_HOLD = STOP_HOLD_CYCLES
) (
   input  wire logic                 sys_clk_in,          // bus clock, 20 MHz
   input  wire logic                 reset_in,            // sync reset, active high
   input  wire bisc_cfg_req_t        cfg_req_in,          // config space access
   output bisc_cfg_rsp_t             cfg_rsp_out,         // config read answer
   input  wire logic [7:0]           pmu_cfg_rdata_in,    // power unit config read data
   input  wire logic                 pmu_disabled_in,     // power unit function off
   output logic                      pmu_cfg_sel_out,     // access forwarded to power unit
   output bisc_sirq_cfg_t            sirq_cfg_out,        // serial interrupt frame setup
   output logic [7:0]                ddma_pci_side_out,   // per channel, 1 = PCI side
   output logic [7:0]                ddma_base_out,       // distributed DMA base
   input  wire logic                 burst_mode_in,       // soft clock-stop burst enabled
   input  wire logic                 stop_start_in,       // clock-stop request pulse
   input  wire logic                 pmu_stop_release_in, // power unit release pulse
   output logic                      cpu_clock_stop_request_n_out, // clock-stop, low active
   input  wire logic                 usb_port1_power_enable_n_in,  // USB port 1 power
   input  wire logic                 usb_port2_power_enable_n_in,  // USB port 2 power
   input  wire logic [1:0]           gpio_9_8_in,         // normal pin 9/8 values
   output logic [1:0]                gpio_9_8_out,        // pin 9/8 drive values
   input  wire logic [3:0]           ad_31_28_in,         // address lines 31..28
   input  wire logic                 usb_enabled_in,      // internal USB enabled
   output logic                      pmu_idsel_out,       // power unit device select
   output logic                      usb_idsel_out,       // USB device select
   input  wire logic                 dma_cycle_in,        // DMA cycle in progress
   input  wire logic                 ready_drive_in,      // ready wanted outside DMA
   output logic                      isa_ready_oe_out,    // ISA ready output enable
   output logic                      subsys_id_lock_out,  // subsystem ids read-only
   output logic                      battery_base_lock_out, // battery bus base locked
   output logic                      acpi_base_lock_out,  // ACPI base locked
   input  wire logic                 usb_irq_in,          // USB level request
   input  wire logic                 ide_sec_irq_in,      // IDE secondary level request
   input  wire logic                 ide_native_in,       // IDE in native mode
   input  wire logic                 sci_irq_in,          // system control interrupt level
   input  wire logic                 battery_irq_in,      // battery bus event level
   output logic [15:0]               irq_out              // legacy IRQ0..15 lines
);

   typedef struct packed {
      logic [7:0][7:0]     regs;
      logic [NUM_SRC-1:0]  src_prev;
      logic [15:0]         irq_sync;
      logic [31:0]         stop_cnt;
      logic                stop_n;
      logic [7:0]          rdata;
      logic                rvalid;
   } bisc_state_t;

   bisc_state_t state_reg;
   bisc_state_t state_next;

   localparam logic [7:0][7:0] WMASK = {WMASK_77, WMASK_76, WMASK_75, WMASK_74,
                                        WMASK_73, WMASK_72, WMASK_71, WMASK_70};

   logic [7:0] r70;
   logic [7:0] r71;
   logic [7:0] r72;
   logic [7:0] r74;
   logic [7:0] r75;
   logic [7:0] r76;
   logic [7:0] r77;
   logic [2:0] idx;
   logic       in_block;
   logic       in_pmu_map;
   logic [NUM_SRC-1:0]      src_level;
   logic [NUM_SRC-1:0]      src_shaped;
   logic [NUM_SRC-1:0][3:0] src_code;
   logic [NUM_SRC-1:0]      src_allow;
   logic [NUM_SRC-1:0][15:0] src_lines;
   logic [15:0] irq_comb;

   assign r70 = state_reg.regs[0];
   assign r71 = state_reg.regs[1];
   assign r72 = state_reg.regs[2];
   assign r74 = state_reg.regs[4];
   assign r75 = state_reg.regs[5];
   assign r76 = state_reg.regs[6];
   assign r77 = state_reg.regs[7];

   assign idx        = cfg_req_in.addr[2:0];
   assign in_block   = (cfg_req_in.addr[7:3] == OFF_SERIAL_IRQ_CONTROL[7:3]);
   assign in_pmu_map = pmu_disabled_in && (cfg_req_in.addr >= OFF_PMU_MAP_FIRST);

   // common routing table, returns one-hot line or zero
   function automatic logic [15:0] route_line(input logic [3:0] code, input logic system_control_interrupt);
      logic [15:0] l;
      l = 16'h0000;
      case (code)
         4'h0:    l = system_control_interrupt ? (16'h0001 << IRQ13_LINE) : 16'h0000;
         4'h1:    l = 16'h0200;
         4'h2:    l = 16'h0008;
         4'h3:    l = 16'h0400;
         4'h4:    l = 16'h0010;
         4'h5:    l = 16'h0020;
         4'h6:    l = 16'h0080;
         4'h7:    l = 16'h0040;
         4'h8:    l = 16'h0002;
         4'h9:    l = 16'h0800;
         4'hb:    l = 16'h1000;
         4'hd:    l = 16'h4000;
         4'hf:    l = 16'h8000;
         default: l = 16'h0000;
      endcase
      return l;
   endfunction : route_line

   assign src_level = {battery_irq_in, sci_irq_in, ide_sec_irq_in, usb_irq_in};
   assign src_code  = {r77[ROUTE_CODE_LSB +: 4], r76[ROUTE_CODE_LSB +: 4],
                       r75[ROUTE_CODE_LSB +: 4], r74[ROUTE_CODE_LSB +: 4]};
   assign src_allow = {1'b1, 1'b1, ide_native_in, 1'b1};

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         logic edge_en;
         logic [15:0] l;
         assign edge_en = state_reg.regs[4 + g][EDGE_BIT];
         // one-cycle high pulse on each new assertion
         assign src_shaped[g] = edge_en ? (src_level[g] & ~state_reg.src_prev[g]) : src_level[g];
         assign l = route_line(src_code[g], (g == 2));
         // code 0000 to IRQ13 only while the inverted permit bit is clear
         assign src_lines[g] = (src_allow[g] && src_shaped[g] &&
                                !((g == 2) && (src_code[g] == 4'h0) && r76[SCI_IRQ13_OFF_BIT]))
                               ? l : 16'h0000;
      end
   endgenerate

   always_comb begin
      irq_comb = 16'h0000;
      for (int s = 0; s < NUM_SRC; s++) begin
         irq_comb = irq_comb | src_lines[s];
      end
   end

   always_comb begin
      state_next          = state_reg;
      state_next.src_prev = src_level;
      state_next.irq_sync = irq_comb;
      state_next.rvalid   = cfg_req_in.rd;
      if (cfg_req_in.wr && in_block) begin
         state_next.regs[idx] = cfg_req_in.wdata & WMASK[idx];
      end
      if (cfg_req_in.rd) begin
         if (in_pmu_map) begin
            state_next.rdata = pmu_cfg_rdata_in;
         end else if (in_block) begin
            state_next.rdata = state_reg.regs[idx];
         end else begin
            state_next.rdata = 8'h00;
         end
      end
      // clock-stop request and its release
      if (stop_start_in && burst_mode_in) begin
         state_next.stop_n   = 1'b0;
         state_next.stop_cnt = 32'h0000_0000;
      end else if (!state_reg.stop_n) begin
         if (r71[STOP_SELECT_BIT]) begin
            if (state_reg.stop_cnt >= 32'(STOP_HOLD - 1)) begin
               state_next.stop_n = 1'b1;
            end else begin
               state_next.stop_cnt = state_reg.stop_cnt + 32'h0000_0001;
            end
         end else if (pmu_stop_release_in) begin
            state_next.stop_n = 1'b1;
         end
      end
      if (reset_in) begin
         state_next.regs     = '0;
         state_next.regs[0]  = RST_SERIAL_IRQ_CONTROL;
         state_next.src_prev = '0;
         state_next.irq_sync = 16'h0000;
         state_next.stop_cnt = 32'h0000_0000;
         state_next.stop_n   = 1'b1;
         state_next.rdata    = 8'h00;
         state_next.rvalid   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      state_reg <= state_next;
   end

   assign cfg_rsp_out.rdata  = state_reg.rdata;
   assign cfg_rsp_out.rvalid = state_reg.rvalid;
   assign pmu_cfg_sel_out    = (cfg_req_in.rd || cfg_req_in.wr) && in_pmu_map;

   always_comb begin
      sirq_cfg_out.enable            = r70[SIRQ_ENABLE_BIT];
      sirq_cfg_out.repeat_continuous = r72[REPEAT_CONT_BIT];
      sirq_cfg_out.stop_clocks       = r70[SIRQ_STOP_BIT] ? STOP_CONT : STOP_QUIET;
      sirq_cfg_out.slot_count        = 6'(SLOT_BASE) + 6'(r70[SIRQ_FRAMES_LSB +: 4]);
      sirq_cfg_out.start_reserved    = 1'b0;
      case (r70[SIRQ_START_LSB +: 2])
         2'h0:    sirq_cfg_out.start_clocks = START_W0;
         2'h1:    sirq_cfg_out.start_clocks = START_W1;
         2'h2:    sirq_cfg_out.start_clocks = START_W2;
         default: begin
            sirq_cfg_out.start_clocks   = START_W2;
            sirq_cfg_out.start_reserved = 1'b1;
         end
      endcase
   end

   assign ddma_pci_side_out = {r71[7:5], 1'b0, r71[3:0]};
   assign ddma_base_out     = state_reg.regs[3];
   assign cpu_clock_stop_request_n_out = state_reg.stop_n;

   assign gpio_9_8_out = r72[USB_PWREN_GPIO_BIT]
                         ? {usb_port2_power_enable_n_in, usb_port1_power_enable_n_in}
                         : gpio_9_8_in;

   assign pmu_idsel_out = ad_31_28_in[r72[PMU_IDSEL_LSB +: 2]];
   assign usb_idsel_out = usb_enabled_in &&
                          ad_31_28_in[2'h3 - r72[USB_IDSEL_LSB +: 2]];

   assign isa_ready_oe_out = dma_cycle_in ? !r74[READY_NODRIVE_BIT] : ready_drive_in;
   assign subsys_id_lock_out    = r74[SUBSYS_LOCK_BIT];
   assign battery_base_lock_out = r77[BATTERY_LOCK_BIT];
   assign acpi_base_lock_out    = r77[ACPI_LOCK_BIT];

   assign irq_out = r72[SYNC_BIT] ? state_reg.irq_sync : irq_comb;

endmodule : bisc_bridge_irq_steering_config
`default_nettype wire

// file: verification/bisc_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bisc_irq_monitor
   import bisc_pkg::*;
(
   input wire logic           sys_clk_in,                   // clock
   input wire logic           reset_in,                     // reset
   input wire bisc_cfg_req_t  cfg_req_in,                   // request
   input wire bisc_cfg_rsp_t  cfg_rsp_out,                  // answer
   input wire logic           pmu_disabled_in,              // unit off
   input wire logic           pmu_cfg_sel_out,              // forward
   input wire bisc_sirq_cfg_t sirq_cfg_out,                 // frame setup
   input wire logic [7:0]     ddma_pci_side_out,            // dma side
   input wire logic           burst_mode_in,                // burst
   input wire logic           stop_start_in,                // stop pulse
   input wire logic           cpu_clock_stop_request_n_out, // stop
   input wire logic           usb_irq_in,                   // src
   input wire logic           ide_sec_irq_in,               // src
   input wire logic           sci_irq_in,                   // src
   input wire logic           battery_irq_in,               // src
   input wire logic [15:0]    irq_out                       // lines
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   wire logic quiet = !(usb_irq_in | ide_sec_irq_in | sci_irq_in | battery_irq_in);
   sequence s_stop_req;
      stop_start_in && burst_mode_in;
   endsequence
   sequence s_stop_low;
      !cpu_clock_stop_request_n_out;
   endsequence
   AST_STOP_TAKEN: assert property (s_stop_req |=> s_stop_low)
      else $error("clock stop not taken");
   AST_STOP_CAUSE: assert property ($fell(cpu_clock_stop_request_n_out) |-> $past(stop_start_in))
      else $error("clock stop without request");
   AST_RD_ANSWER: assert property (cfg_req_in.rd |=> cfg_rsp_out.rvalid)
      else $error("read not answered");
   AST_NO_ANSWER: assert property (!cfg_req_in.rd |=> !cfg_rsp_out.rvalid)
      else $error("answer without read");
   AST_SLOTS: assert property (sirq_cfg_out.slot_count inside {[17:32]})
      else $error("slot count out of range");
   AST_STOP_W: assert property (sirq_cfg_out.stop_clocks inside {2, 3})
      else $error("bad stop width");
   AST_START_W: assert property (sirq_cfg_out.start_clocks inside {4, 6, 8})
      else $error("bad start width");
   AST_CH4: assert property (!ddma_pci_side_out[4])
      else $error("channel four on pci side");
   AST_NO_LINE: assert property ((irq_out & 16'h0105) == 16'h0000)
      else $error("line outside table driven");
   AST_QUIET: assert property (quiet && $past(quiet) |-> irq_out == 16'h0000)
      else $error("line driven without source");
   AST_PMU_SEL: assert property (pmu_cfg_sel_out == ((cfg_req_in.rd || cfg_req_in.wr)
      && cfg_req_in.addr >= 8'h7c && pmu_disabled_in)) else $error("bad power unit select");
endmodule : bisc_irq_monitor
`default_nettype wire

// file: verification/bisc_pmu_model.sv
`timescale 1ns/1ps
`default_nettype none
module bisc_pmu_model
   import bisc_pkg::*;
(
   input  wire bisc_cfg_req_t req_in,    // forwarded access
   output logic [7:0]         rdata_out  // unit read data
);
   // idle bus shows inverted pattern
   assign rdata_out = req_in.rd ? (req_in.addr ^ 8'h5a) : ~(req_in.addr ^ 8'h5a);
endmodule : bisc_pmu_model
`default_nettype wire

// file: verification/bisc_bridge_irq_steering_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bisc_bridge_irq_steering_config_tb
   import bisc_pkg::*;
;
   localparam int LUT[16] = '{0, 9, 3, 10, 4, 5, 7, 6, 1, 11, 0, 12, 0, 14, 0, 15};
   localparam logic [7:0] SV[4] = '{8'hc1, 8'h3c, 8'hff, 8'h22};
   logic clk;
   logic rst = 1'b1;
   bisc_cfg_req_t rq = '0;
   bisc_cfg_rsp_t rs;
   bisc_sirq_cfg_t sc;
   logic [7:0] prd, ds, db;
   logic dis = 0, bm = 0, ss = 0, pr = 0, p1 = 0, p2 = 1, ue = 1, dma = 0, rdy = 1, inat = 1;
   logic [1:0] gin = 2'b01, gout;
   logic [3:0] ad = 4'h0, src = 4'h0;
   logic stop_n, sel, pid, uid, oe, l0, l1, l2;
   logic [15:0] irq;
   int fail_count = 0, total_checks = 0;
   bisc_pmu_model u_bisc_pmu_model (.req_in(rq), .rdata_out(prd));
   bisc_bridge_irq_steering_config #(.STOP_HOLD(20)) u_bisc_bridge_irq_steering_config (
      .sys_clk_in(clk), .reset_in(rst), .cfg_req_in(rq), .cfg_rsp_out(rs), .pmu_cfg_rdata_in(prd),
      .pmu_disabled_in(dis), .pmu_cfg_sel_out(sel), .sirq_cfg_out(sc), .ddma_pci_side_out(ds),
      .ddma_base_out(db), .burst_mode_in(bm), .stop_start_in(ss), .pmu_stop_release_in(pr),
      .cpu_clock_stop_request_n_out(stop_n), .usb_port1_power_enable_n_in(p1),
      .usb_port2_power_enable_n_in(p2), .gpio_9_8_in(gin), .gpio_9_8_out(gout), .ad_31_28_in(ad),
      .usb_enabled_in(ue), .pmu_idsel_out(pid), .usb_idsel_out(uid), .dma_cycle_in(dma),
      .ready_drive_in(rdy), .isa_ready_oe_out(oe), .subsys_id_lock_out(l0), .battery_base_lock_out(l1),
      .acpi_base_lock_out(l2), .usb_irq_in(src[0]), .ide_sec_irq_in(src[1]), .ide_native_in(inat),
      .sci_irq_in(src[2]), .battery_irq_in(src[3]), .irq_out(irq));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task chk(input logic [23:0] g, e);
      total_checks++;
      if (g !== e) begin
         $display("ERROR %0t got %h exp %h", $time, g, e);
         fail_count++;
      end
   endtask : chk
   task wr(input logic [7:0] a, d);
      rq <= '{a, 1'b1, 1'b0, d};
      @(posedge clk);
      rq <= '0;
      @(posedge clk);
   endtask : wr
   task rd(input logic [7:0] a, e);
      rq <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge clk);
      rq <= '0;
      #1 chk({rs.rvalid, rs.rdata}, {1'b1, e});
      @(posedge clk);
   endtask : rd
   task t_sirq;
      logic [7:0] v;
      for (int a = 8'h71; a < 8'h78; a++) rd(a[7:0], 8'h00);
      chk(sc, {1'b0, 1'b0, 4'h2, 6'd21, 4'h8, 1'b0});
      for (int i = 0; i < 4; i++) begin
         v = SV[i];
         wr(8'h70, v);
         chk(sc, {v[7], 1'b0, v[6] ? 4'h3 : 4'h2, 6'd17 + v[5:2],
            v[1] ? 4'h8 : (v[0] ? 4'h6 : 4'h4), v[1:0] == 2'b11});
         rd(8'h70, v);
      end
   endtask : t_sirq
   task t_regs;
      dma <= 1'b1;
      wr(8'h71, 8'hff);
      chk(ds, 8'hef);
      wr(8'h73, 8'ha5);
      chk(db, 8'ha5);
      rd(8'h73, 8'ha5);
      wr(8'h74, 8'hff);
      chk({oe, l0}, 2'b01);
      rd(8'h74, 8'hdf);
      wr(8'h74, 8'h00);
      chk({oe, l0}, 2'b10);
      dma <= 1'b0;
      rdy <= 1'b0;
      @(posedge clk);
      #1 chk(oe, 1'b0);
      @(posedge clk);
      rdy <= 1'b1;
      #1 chk(oe, 1'b1);
      @(posedge clk);
      dma <= 1'b1;
      wr(8'h77, 8'hc0);
      chk({l1, l2}, 2'b11);
      wr(8'h77, 8'h00);
      chk({l1, l2}, 2'b00);
      wr(8'h72, 8'h70);
      chk({sc.repeat_continuous, gout}, 3'b110);
      rd(8'h72, 8'h60);
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 4; k++) begin
            ad <= 4'h1 << k;
            wr(8'h72, {4'h0, c[1:0], c[1:0]});
            chk({pid, uid, gout}, {k == c, k == 3 - c, 2'b01});
         end
      end
   endtask : t_regs
   task t_route;
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 16; c++) begin
            wr(8'h74 + s[7:0], c[7:0]);
            src <= 4'h1 << s;
            #1 chk(irq, (s == 2 && c == 0) ? 16'h2000 : (LUT[c] == 0 ? 16'h0 : 16'h1 << LUT[c]));
            @(posedge clk);
            src <= 4'h0;
         end
      end
      wr(8'h76, 8'h80);
      inat <= 1'b0;
      src <= 4'h6;
      #1 chk(irq, 16'h0000);
      @(posedge clk);
      src <= 4'h0;
      inat <= 1'b1;
   endtask : t_route
   task t_edge;
      wr(8'h74, 8'h11);
      src <= 4'h1;
      #1 chk(irq, 16'h0200);
      @(posedge clk);
      #1 chk(irq, 16'h0000);
      @(posedge clk);
      src <= 4'h0;
      wr(8'h72, 8'h80);
      wr(8'h74, 8'h01);
      src <= 4'h1;
      #1 chk(irq, 16'h0000);
      @(posedge clk);
      #1 chk(irq, 16'h0200);
      @(posedge clk);
      src <= 4'h0;
      wr(8'h72, 8'h00);
   endtask : t_edge
   task t_stop;
      bm <= 1'b1;
      wr(8'h71, 8'h10);
      ss <= 1'b1;
      @(posedge clk);
      ss <= 1'b0;
      #1 chk(stop_n, 1'b0);
      repeat (19) @(posedge clk);
      #1 chk(stop_n, 1'b0);
      @(posedge clk);
      #1 chk(stop_n, 1'b1);
      @(posedge clk);
      wr(8'h71, 8'h00);
      ss <= 1'b1;
      @(posedge clk);
      ss <= 1'b0;
      repeat (30) @(posedge clk);
      pr <= 1'b1;
      #1 chk(stop_n, 1'b0);
      @(posedge clk);
      pr <= 1'b0;
      #1 chk(stop_n, 1'b1);
      @(posedge clk);
   endtask : t_stop
   task t_map;
      dis <= 1'b1;
      rd(8'h80, 8'hda);
      dis <= 1'b0;
      rd(8'h80, 8'h00);
      rd(8'h78, 8'h00);
      wr(8'h70, 8'hc1);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h70, 8'h12);
      chk(stop_n, 1'b1);
   endtask : t_map
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h70, 8'h12);
      t_sirq;
      t_regs;
      t_route;
      t_edge;
      t_stop;
      t_map;
      end_of_test;
   end
endmodule : bisc_bridge_irq_steering_config_tb
bind bisc_bridge_irq_steering_config bisc_irq_monitor u_bisc_irq_monitor (.sys_clk_in, .reset_in,
   .cfg_req_in, .cfg_rsp_out, .pmu_disabled_in, .pmu_cfg_sel_out, .sirq_cfg_out, .ddma_pci_side_out,
   .burst_mode_in, .stop_start_in, .cpu_clock_stop_request_n_out, .usb_irq_in, .ide_sec_irq_in,
   .sci_irq_in, .battery_irq_in, .irq_out);
`default_nettype wire
